// File: hw/bbs_exec.sv
// decode and execute of relative jump, bit set and bit test with skip
// Summary of operation
// - jump opcode: top five bits 11010, low eleven bits signed offset n
// - jump target is incremented fetch address plus twice sign-extended offset
// - offset doubled before adding so target stays word aligned
// - jump takes two cycles; second cycle is idle while pipeline refills
// - bit set opcode: 1000, three-bit position, bank flag, eight-bit address
// - bit set reads register, forces bit to one, writes back in one cycle
// - bank flag zero selects fixed access bank, bank select ignored
// - bank flag one uses bank select register with file address
// - extended set, flag zero, address up to 95 uses indexed literal offset
// - opcode 1011 skips next instruction when selected bit is zero
// - opcode 1010 skips next instruction when selected bit is one
// - taken skip discards prefetched instruction, runs idle cycle instead
`timescale 1ns/100ps
module bbs_exec
  import bbs_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // fetch side
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic [PC_W-1:0] FETCH_PC,
  // configuration
  input wire logic [3:0] BANK_SELECT,
  input wire logic EXT_SET_EN,
  // data memory read value for current address, combinational
  input wire logic [7:0] MEM_RDATA,
  // program counter control
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_TARGET,
  output logic FLUSH_PREFETCH,
  // data memory access
  output bbs_mem_s MEM_REQ,
  // status
  output logic IDLE_CYCLE
);
  bbs_state_e state_ff, nxt_state;
  logic pc_load_ff, nxt_pc_load;
  logic [PC_W-1:0] pc_target_ff, nxt_pc_target;
  logic flush_ff, nxt_flush;
  bbs_mem_s mem_ff, nxt_mem;
  logic idle_ff, nxt_idle;

  logic is_jump, is_set, is_tclr, is_tset, sel_bit;
  logic [2:0] bpos;
  logic [7:0] faddr;

  // one function resolves the address for set and both tests
  function automatic logic [ADDR_W:0] resolve_addr(input logic a_flag, input logic [7:0] f,
                                                   input logic [3:0] bank_sel, input logic ext);
    logic [ADDR_W:0] r;
    r = {1'b0, bank_sel, f};
    if (!a_flag)
    begin
      if (ext && (f <= IDX_LIMIT))
        r = {1'b1, 4'h0, f};
      else
        r = {1'b0, (f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : resolve_addr

  always_comb
  begin
    is_jump = (INSTR_WORD[15:11] == OPC_JUMP);
    is_set = (INSTR_WORD[15:12] == OPC_SET);
    is_tclr = (INSTR_WORD[15:12] == OPC_TST_CLR);
    is_tset = (INSTR_WORD[15:12] == OPC_TST_SET);
    bpos = INSTR_WORD[11:9];
    faddr = INSTR_WORD[7:0];
    sel_bit = MEM_RDATA[bpos];
  end

  always_comb
  begin
    logic [ADDR_W:0] ra;
    ra = resolve_addr(INSTR_WORD[8], faddr, BANK_SELECT, EXT_SET_EN);
    nxt_state = ST_EXEC;
    nxt_pc_load = 1'b0;
    nxt_pc_target = pc_target_ff;
    nxt_flush = 1'b0;
    nxt_idle = 1'b0;
    nxt_mem = '0;
    case (state_ff)
      ST_EXEC:
      begin
        if (INSTR_VALID)
        begin
          if (is_jump)
          begin
            // offset doubled by the shift, so bit zero of the target equals bit zero of FETCH_PC
            nxt_pc_target = FETCH_PC + {{(PC_W-12){INSTR_WORD[10]}}, INSTR_WORD[10:0], 1'b0};
            nxt_pc_load = 1'b1;
            nxt_flush = 1'b1;
            nxt_state = ST_FLUSH;
          end
          else if (is_set || is_tclr || is_tset)
          begin
            nxt_mem.addr = ra[ADDR_W-1:0];
            nxt_mem.indexed = ra[ADDR_W];
            nxt_mem.re = 1'b1;
            if (is_set)
            begin
              // status flags are untouched: this block drives no flag outputs
              nxt_mem.we = 1'b1;
              nxt_mem.data = MEM_RDATA | (8'h01 << bpos);
            end
            else if ((is_tclr && !sel_bit) || (is_tset && sel_bit))
            begin
              nxt_flush = 1'b1;
              nxt_state = ST_FLUSH;
            end
          end
        end
      end
      ST_FLUSH:
      begin
        // prefetched word is dropped here; nothing else happens this cycle
        nxt_idle = 1'b1;
        nxt_state = ST_EXEC;
      end
      default:
      begin
        nxt_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      state_ff <= ST_EXEC;
      pc_load_ff <= 1'b0;
      pc_target_ff <= PC_RESET;
      flush_ff <= 1'b0;
      mem_ff <= '0;
      idle_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pc_load_ff <= nxt_pc_load;
      pc_target_ff <= nxt_pc_target;
      flush_ff <= nxt_flush;
      mem_ff <= nxt_mem;
      idle_ff <= nxt_idle;
    end
  end

  always_comb
  begin
    PC_LOAD = pc_load_ff;
    PC_TARGET = pc_target_ff;
    FLUSH_PREFETCH = flush_ff;
    MEM_REQ = mem_ff;
    IDLE_CYCLE = idle_ff;
  end

  // assertions
  sequence s_jump_seen;
    INSTR_VALID && state_ff == ST_EXEC && is_jump;
  endsequence

  sequence s_jump_done;
    PC_LOAD && FLUSH_PREFETCH ##1 IDLE_CYCLE && !PC_LOAD;
  endsequence

  property p_jump_two_cycles;
    @(posedge CLK_SYS) disable iff (RESET) s_jump_seen |=> s_jump_done;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles) else $error("jump not two cycles");

  property p_jump_target;
    @(posedge CLK_SYS) disable iff (RESET)
      s_jump_seen |=> PC_TARGET == $past(FETCH_PC) + {{(PC_W-12){$past(INSTR_WORD[10])}}, $past(INSTR_WORD[10:0]), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_target_aligned;
    @(posedge CLK_SYS) disable iff (RESET) PC_LOAD |-> (PC_TARGET[0] == $past(FETCH_PC[0]));
  endproperty
  a_target_aligned: assert property (p_target_aligned) else $error("target misaligned");

  property p_set_bit;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_set |=>
        MEM_REQ.we && MEM_REQ.data[$past(bpos)] && ((MEM_REQ.data | ~(8'h01 << $past(bpos))) != 8'h00) &&
        ((MEM_REQ.data & ~(8'h01 << $past(bpos))) == ($past(MEM_RDATA) & ~(8'h01 << $past(bpos))));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

  property p_access_bank;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_set && !INSTR_WORD[8] && !EXT_SET_EN |=>
        MEM_REQ.addr[7:0] == $past(faddr) && !MEM_REQ.indexed &&
        MEM_REQ.addr[11:8] == (($past(faddr) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK);
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

  property p_banked;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_set && INSTR_WORD[8] |=> MEM_REQ.addr == {$past(BANK_SELECT), $past(faddr)};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_set && !INSTR_WORD[8] && EXT_SET_EN |=>
        MEM_REQ.indexed == ($past(faddr) <= IDX_LIMIT);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed mode wrong");

  property p_skip_clear;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_tclr |=> FLUSH_PREFETCH == !$past(sel_bit) && !MEM_REQ.we;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip when clear wrong");

  property p_skip_set;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && is_tset |=> FLUSH_PREFETCH == $past(sel_bit) && !PC_LOAD;
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip when set wrong");

  property p_skip_idle;
    @(posedge CLK_SYS) disable iff (RESET) FLUSH_PREFETCH && !PC_LOAD |=> IDLE_CYCLE ##1 !IDLE_CYCLE;
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("skip idle missing");

  property p_decode_jump;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && INSTR_WORD[15:11] != OPC_JUMP |=> !PC_LOAD;
  endproperty
  a_decode_jump: assert property (p_decode_jump) else $error("false jump decode");

  property p_decode_set;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && INSTR_WORD[15:12] != OPC_SET |=> !MEM_REQ.we;
  endproperty
  a_decode_set: assert property (p_decode_set) else $error("false set decode");

  // helper sequences for the set and test paths
  sequence s_set_seen;
    INSTR_VALID && state_ff == ST_EXEC && is_set;
  endsequence

  sequence s_test_seen;
    INSTR_VALID && state_ff == ST_EXEC && (is_tclr || is_tset);
  endsequence

  // the word fetched behind a jump or taken skip must never act
  property p_flush_quiet;
    @(posedge CLK_SYS) disable iff (RESET)
      state_ff == ST_FLUSH |=> IDLE_CYCLE && !PC_LOAD && !FLUSH_PREFETCH && MEM_REQ == '0;
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("dropped word acted");

  property p_set_one_cycle;
    @(posedge CLK_SYS) disable iff (RESET)
      s_set_seen |=> MEM_REQ.re && !FLUSH_PREFETCH && !PC_LOAD ##1 !IDLE_CYCLE;
  endproperty
  a_set_one_cycle: assert property (p_set_one_cycle) else $error("bit set not one cycle");

  property p_test_read_only;
    @(posedge CLK_SYS) disable iff (RESET)
      s_test_seen |=> MEM_REQ.re && !MEM_REQ.we && !PC_LOAD;
  endproperty
  a_test_read_only: assert property (p_test_read_only) else $error("bit test wrote");

  property p_test_banked;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && (is_tclr || is_tset) && INSTR_WORD[8] |=>
        MEM_REQ.addr == {$past(BANK_SELECT), $past(faddr)} && !MEM_REQ.indexed;
  endproperty
  a_test_banked: assert property (p_test_banked) else $error("test banked address wrong");

  property p_test_access;
    @(posedge CLK_SYS) disable iff (RESET)
      INSTR_VALID && state_ff == ST_EXEC && (is_tclr || is_tset) && !INSTR_WORD[8] && !EXT_SET_EN |=>
        MEM_REQ.addr == {(($past(faddr) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK), $past(faddr)};
  endproperty
  a_test_access: assert property (p_test_access) else $error("test access bank wrong");

  property p_idle_after_flush;
    @(posedge CLK_SYS) disable iff (RESET) IDLE_CYCLE |-> $past(FLUSH_PREFETCH);
  endproperty
  a_idle_after_flush: assert property (p_idle_after_flush) else $error("idle without flush");

  property p_flush_pulse;
    @(posedge CLK_SYS) disable iff (RESET) FLUSH_PREFETCH |=> !FLUSH_PREFETCH;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than one cycle");

  // the target only moves with its load pulse, so the core may read it late
  property p_target_holds;
    @(posedge CLK_SYS) disable iff (RESET) !PC_LOAD |-> $stable(PC_TARGET);
  endproperty
  a_target_holds: assert property (p_target_holds) else $error("target moved without load");

  property p_jump_no_mem;
    @(posedge CLK_SYS) disable iff (RESET) s_jump_seen |=> MEM_REQ == '0;
  endproperty
  a_jump_no_mem: assert property (p_jump_no_mem) else $error("jump touched memory");
endmodule : bbs_exec

// File: include/bbs_pkg.sv
// package for the branch, bit-set and bit-test execute block
package bbs_pkg;
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam logic [4:0] OPC_JUMP = 5'h1A;
  localparam logic [3:0] OPC_SET = 4'h8;
  localparam logic [3:0] OPC_TST_CLR = 4'hB;
  localparam logic [3:0] OPC_TST_SET = 4'hA;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0]
  {
    ST_EXEC = 2'h0,
    ST_FLUSH = 2'h1
  } bbs_state_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic we;
    logic re;
    logic indexed;
  } bbs_mem_s;
endpackage : bbs_pkg

// File: tb/bbs_mem_model.sv
// file register model answering the block's reads and bit-set writes
`timescale 1ns/100ps
module bbs_mem_model
  import bbs_pkg::*;
(
  // clock
  input wire logic clk,
  // word under decode and registered access
  input wire logic [15:0] word,
  input wire bbs_mem_s req,
  // read data
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0];
  end
  // banks alias onto one page to keep the model small
  assign rdata = mem[word[7:0]];
  always @(posedge clk)
    if (req.we)
      mem[req.addr[7:0]] <= req.data;
endmodule : bbs_mem_model

// File: tb/testbench.sv
// self-checking bench for the jump, bit-set and bit-test block
`timescale 1ns/100ps
module testbench;
  import bbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic [15:0] wrd = 16'h0000;
  logic [PC_W-1:0] fpc = '0;
  logic [3:0] bsel = 4'h0;
  logic ext = 1'b0;
  logic [7:0] rdata;
  logic pc_load, flush, idle, sk, i2;
  logic [PC_W-1:0] tgt, jt;
  logic [2:0] c1;
  logic [3:0] op;
  bbs_mem_s req, r1, r2, ex;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [10:0] offs [3] = '{11'h7FF, 11'h3FF, 11'h400};
  logic [7:0] sf [5] = '{8'h12, 8'h70, 8'h21, 8'h22, 8'h60};
  logic [11:0] sx [5] = '{12'h312, 12'hF70, 12'h021, 12'h022, 12'hF60};
  always #20 clk = ~clk;
  bbs_exec DUT (.CLK_SYS(clk), .RESET(rst), .INSTR_VALID(vld), .INSTR_WORD(wrd), .FETCH_PC(fpc),
    .BANK_SELECT(bsel), .EXT_SET_EN(ext), .MEM_RDATA(rdata), .PC_LOAD(pc_load), .PC_TARGET(tgt),
    .FLUSH_PREFETCH(flush), .MEM_REQ(req), .IDLE_CYCLE(idle));
  bbs_mem_model u_mem (.clk(clk), .word(wrd), .req(req), .rdata(rdata));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] enc(input logic [3:0] o, input int b, input logic a, input logic [7:0] f);
    return {o, b[2:0], a, f};
  endfunction : enc
  // w is taken at the second edge, w2 at the third, where a flush must drop it
  task automatic run(input logic [15:0] w, input logic [15:0] w2, input logic [PC_W-1:0] p, input logic e);
    @(posedge clk);
    vld <= 1'b1;
    wrd <= w;
    fpc <= p;
    bsel <= 4'h3;
    ext <= e;
    @(posedge clk);
    wrd <= w2;
    #1;
    c1 = {pc_load, flush, idle};
    r1 = req;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    i2 = idle;
    r2 = req;
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // ceiling well above the 56 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset pulses", {pc_load, flush, idle, req}, '0);
    chk("reset target", tgt, '0);
    foreach (offs[k])
    begin
      run({OPC_JUMP, offs[k]}, enc(OPC_SET, 0, 1'b1, 8'h40), 21'h01000, 1'b0);
      jt = 21'h01000 + {{9{offs[k][10]}}, offs[k], 1'b0};
      chk("jump pulses", c1, 3'b110);
      chk("jump target", tgt, jt);
      chk("jump idle", i2, 1'b1);
      chk("prefetch dropped", r2, '0);
    end
    for (int k = 0; k < 5; k++)
    begin
      run(enc(OPC_SET, (k + 7) % 8, k == 0, sf[k]), 16'h0000, 21'h0, k > 2);
      ex = '{addr: sx[k], data: sf[k] | (8'h01 << ((k + 7) % 8)), we: 1'b1, re: 1'b1, indexed: k == 3};
      chk("set access", r1, ex);
      chk("set one cycle", {c1, i2, r2}, '0);
    end
    for (int k = 0; k < 4; k++)
    begin
      op = (k < 2) ? OPC_TST_CLR : OPC_TST_SET;
      sk = (k == 0) || (k == 2);
      // set k=0 left 8'h92 at 8'h12: bit 7 set, bit 0 clear
      run(enc(op, (k == 1 || k == 2) ? 7 : 0, k < 2, 8'h12), enc(OPC_SET, 0, 1'b1, 8'h40), 21'h0, 1'b0);
      chk("test pulses", c1, {1'b0, sk, 1'b0});
      chk("test read", {r1.re, r1.we, r1.addr}, {2'b10, (k < 2) ? 12'h312 : 12'h012});
      chk("skip idle", {i2, r2.we}, {sk, !sk});
    end
    report_and_stop();
  end
endmodule : testbench
